// File: core/lsout_pkg.sv
// Constants for the per-port LED status output block
package lsout_pkg;
	localparam int         PORTS       = 8;
	localparam int         CLK_HZ      = 25_000_000;
	localparam int         BLINK_MS_A  = 48;
	localparam int         BLINK_MS_B  = 128;
	localparam int         BLINK_CYC_A = CLK_HZ / 1000 * BLINK_MS_A;
	localparam int         BLINK_CYC_B = CLK_HZ / 1000 * BLINK_MS_B;
	localparam int         DIAG_MS     = 256;
	localparam int         DIAG_CYC    = CLK_HZ / 1000 * DIAG_MS;
	localparam int         SCLK_DIV    = 4;
	localparam int         FRAME_GAP   = 16;
	localparam logic [1:0] FMT_SER3    = 2'h0;
	localparam logic [1:0] FMT_SER2    = 2'h1;
	localparam logic [1:0] FMT_BICOL   = 2'h2;
	localparam logic [1:0] FMT_DIRECT  = 2'h3;
	// Wishbone map: byte addresses
	localparam logic [3:0] ADR_CFG     = 4'h0;
	localparam logic [3:0] ADR_STAT    = 4'h4;
	localparam logic [3:0] ADR_CTRL    = 4'h8;
	localparam int         CFG_FMT_LSB = 0;
	localparam int         CFG_KEEP    = 2;
	localparam int         CFG_PER     = 3;
	localparam int         CFG_INH     = 4;
	localparam int         CTRL_FORCE  = 0;
	localparam logic       CTRL_RST    = 1'b0;
endpackage

// File: core/lsout_core.sv
// Per-port LED status formatter: serial streams, bi-color and direct drive
`timescale 1ns/1ps
// Function
// - Latch format and blink straps at reset
// - Format strap picks stream or direct drive
// - Indications active low, bi-color link excepted
// - Duplex low full, blinks on collision
// - Bi-color with keep zero: no collision blink
// - Three-bit serial: link drives low
// - Bi-color 100M link drives high
// - Bi-color 10M link drives low
// - Link indication toggles on traffic
// - Speed low at 100M, high 10M
// - Blink period strap picks 48 or 128ms
// - Ports shifted out 0 through 7
// - Two-bit group: speed then link
// - Three-bit group: duplex, link, speed
// - Bi-color 100M green, blinks 1-0-1-0
// - Bi-color 10M yellow, blinks 0-1-0-1
// - Startup blink when inhibit strap low
module lsout_core
	import lsout_pkg::*;
#(
	parameter int N_PORTS   = PORTS,
	parameter int CYC_A     = BLINK_CYC_A,
	parameter int CYC_B     = BLINK_CYC_B,
	parameter int CYC_DIAG  = DIAG_CYC
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Straps
	input  wire logic [1:0]         led_format_select_i,
	input  wire logic               collision_blink_keep_strap_i,
	input  wire logic               blink_period_select_i,
	input  wire logic               startup_blink_inhibit_i,
	// Port status
	input  wire logic [N_PORTS-1:0] link_up_i,
	input  wire logic [N_PORTS-1:0] speed_100_i,
	input  wire logic [N_PORTS-1:0] full_duplex_i,
	input  wire logic [N_PORTS-1:0] collision_i,
	input  wire logic [N_PORTS-1:0] activity_i,
	// Wishbone slave
	input  wire logic               cyc_i,
	input  wire logic               stb_i,
	input  wire logic               we_i,
	input  wire logic [3:0]         adr_i,
	input  wire logic [3:0]         sel_i,
	input  wire logic [31:0]        dat_i,
	output logic      [31:0]        dat_o,
	output logic                    ack_o,
	// Serial stream
	output logic                    led_data_o,
	output logic                    led_clk_o,
	// Direct drive
	output logic [N_PORTS-1:0]      col_dup_led_o,
	output logic [N_PORTS-1:0]      link_act_led_o,
	output logic [N_PORTS-1:0]      spd_led_o
);
	// ****************************************
	// Strap capture
	// ****************************************
	logic [1:0] fmt;
	logic       collision_blink_keep;
	logic       per_long;
	logic       inh;
	logic       rst_q;
	always_ff @(posedge clk_i) begin
		rst_q <= rst_i;
		if (rst_i) begin
			fmt                  <= led_format_select_i;
			collision_blink_keep <= collision_blink_keep_strap_i;
			per_long             <= blink_period_select_i;
			inh                  <= startup_blink_inhibit_i;
		end
	end

	// ****************************************
	// Blink timebase
	// ****************************************
	logic [23:0] bcnt;
	logic        bph;
	wire  [23:0] half_cyc = per_long ? 24'(CYC_B / 2) : 24'(CYC_A / 2);
	wire         bwrap    = bcnt >= half_cyc - 24'h1;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bcnt <= 24'h0;
			bph  <= 1'b0;
		end else begin
			bcnt <= bwrap ? 24'h0 : bcnt + 24'h1;
			if (bwrap)
				bph <= ~bph;
		end
	end

	// ****************************************
	// Startup diagnostic and register file
	// ****************************************
	logic [24:0] dcnt;
	logic        diag;
	logic        force_on;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dcnt <= 25'h0;
			diag <= 1'b0;
		end else if (rst_q) begin
			diag <= ~inh;
		end else if (diag) begin
			dcnt <= dcnt + 25'h1;
			if (dcnt == 25'(CYC_DIAG - 1))
				diag <= 1'b0;
		end
	end

	wire req  = cyc_i & stb_i & ~ack_o;
	wire wr_c = req & we_i & (adr_i == ADR_CTRL) & sel_i[0];
	wire [31:0] rd_cfg  = {27'h0, inh, per_long, collision_blink_keep, fmt};
	wire [31:0] rd_stat = {30'h0, diag, bph};
	wire [31:0] rd_ctrl = {31'h0, force_on};
	wire [31:0] rd_mux  = (adr_i == ADR_CFG)  ? rd_cfg  :
	                      (adr_i == ADR_STAT) ? rd_stat :
	                      (adr_i == ADR_CTRL) ? rd_ctrl : 32'h0;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o    <= 1'b0;
			dat_o    <= 32'h0;
			force_on <= CTRL_RST;
		end else begin
			ack_o <= req;
			dat_o <= req ? rd_mux : 32'h0;
			if (wr_c)
				force_on <= dat_i[CTRL_FORCE];
		end
	end

	// ****************************************
	// Per-port indications
	// ****************************************
	logic [N_PORTS-1:0] ind_col;
	logic [N_PORTS-1:0] ind_lnk;
	logic [N_PORTS-1:0] ind_spd;
	wire bicol  = fmt == FMT_BICOL;
	wire all_on = diag | force_on;
	genvar g;
	generate
		for (g = 0; g < N_PORTS; g++) begin : g_port
			wire blink_col = collision_i[g] &
			                 ~(bicol & ~collision_blink_keep);
			wire col_v = blink_col ? bph : ~full_duplex_i[g];
			wire spd_v = ~speed_100_i[g];
			// Bi-color link level: high at 100M, low at 10M
			wire lvl   = bicol ? speed_100_i[g] : 1'b0;
			wire lnk_v = ~link_up_i[g] ? (bicol ? spd_v : 1'b1) :
			             activity_i[g] ? (lvl ^ bph) :
			             lvl;
			// Active low; diag lights everything
			assign ind_col[g] = all_on ? 1'b0 : col_v;
			assign ind_lnk[g] = all_on ? (bicol & speed_100_i[g]) : lnk_v;
			assign ind_spd[g] = all_on ? 1'b0 : spd_v;
		end
	endgenerate

	// ****************************************
	// Serial framing and direct drive
	// ****************************************
	localparam int NB = 3 * N_PORTS;
	logic [NB-1:0] shreg;
	logic [5:0]    bidx;
	logic [1:0]    dcyc;
	logic [4:0]    gap;
	// High while a frame bit stands on the data pin
	logic          bit_live;
	wire  [4:0]    bits_now = (fmt == FMT_SER2) ? 5'd2 : 5'd3;
	wire  [5:0]    nbits    = 6'(bits_now * 5'(N_PORTS));
	logic [NB-1:0] frame;
	always_comb begin
		frame = '0;
		for (int p = 0; p < N_PORTS; p++) begin
			// Bit 0 is sent first: port 0 first
			if (fmt == FMT_SER2) begin
				frame[2*p]   = ind_spd[p];
				frame[2*p+1] = ind_lnk[p];
			end else begin
				frame[3*p]   = ind_col[p];
				frame[3*p+1] = ind_lnk[p];
				frame[3*p+2] = ind_spd[p];
			end
		end
	end
	wire serial = fmt != FMT_DIRECT;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shreg      <= '0;
			bidx       <= 6'h0;
			dcyc       <= 2'h0;
			gap        <= 5'(FRAME_GAP);
			bit_live   <= 1'b0;
			led_clk_o  <= 1'b1;
			led_data_o <= 1'b1;
		end else if (!serial) begin
			led_clk_o  <= 1'b1;
			led_data_o <= 1'b1;
		end else begin
			dcyc <= dcyc + 2'h1;
			if (dcyc == 2'(SCLK_DIV / 2 - 1))
				led_clk_o <= bit_live;
			if (dcyc == 2'(SCLK_DIV - 1)) begin
				led_clk_o <= 1'b0;
				if (gap != 5'h0) begin
					gap      <= gap - 5'h1;
					bit_live <= 1'b0;
					if (gap == 5'h1) begin
						shreg <= frame;
						bidx  <= 6'h0;
					end
				end else begin
					led_data_o <= shreg[0];
					bit_live   <= 1'b1;
					shreg      <= shreg >> 1;
					bidx       <= bidx + 6'h1;
					if (bidx == nbits - 6'h1)
						gap <= 5'(FRAME_GAP);
				end
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			col_dup_led_o  <= '1;
			link_act_led_o <= '1;
			spd_led_o      <= '1;
		end else if (serial) begin
			col_dup_led_o  <= '1;
			link_act_led_o <= '1;
			spd_led_o      <= '1;
		end else begin
			col_dup_led_o  <= ind_col;
			link_act_led_o <= ind_lnk;
			spd_led_o      <= ind_spd;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_strap_hold;
		@(posedge clk_i) disable iff (rst_i) ##1 $stable(fmt);
	endproperty
	a_strap_hold: assert property (p_strap_hold)
		else $error("format moved");
	property p_direct_idle;
		@(posedge clk_i) disable iff (rst_i)
		(fmt == FMT_DIRECT) |=> led_clk_o;
	endproperty
	a_direct_idle: assert property (p_direct_idle)
		else $error("clk in direct");
	property p_spd;
		@(posedge clk_i) disable iff (rst_i)
		!all_on |-> ind_spd[0] == ~speed_100_i[0];
	endproperty
	a_spd: assert property (p_spd)
		else $error("speed polarity");
	property p_dup;
		@(posedge clk_i) disable iff (rst_i)
		!all_on && !collision_i[0] |-> ind_col[0] == ~full_duplex_i[0];
	endproperty
	a_dup: assert property (p_dup)
		else $error("duplex polarity");
	property p_nocolblk;
		@(posedge clk_i) disable iff (rst_i)
		bicol && !collision_blink_keep && !all_on
		|-> ind_col[0] == ~full_duplex_i[0];
	endproperty
	a_nocolblk: assert property (p_nocolblk)
		else $error("col blink on");
	property p_ser3_link;
		@(posedge clk_i) disable iff (rst_i)
		fmt == FMT_SER3 && link_up_i[0] && !activity_i[0] && !all_on
		|-> !ind_lnk[0];
	endproperty
	a_ser3_link: assert property (p_ser3_link)
		else $error("link not low");
	property p_bi100;
		@(posedge clk_i) disable iff (rst_i)
		bicol && link_up_i[0] && speed_100_i[0] && !activity_i[0]
		|-> ind_lnk[0] && !ind_spd[0];
	endproperty
	a_bi100: assert property (p_bi100)
		else $error("green wrong");
	property p_bi10;
		@(posedge clk_i) disable iff (rst_i)
		bicol && link_up_i[0] && !speed_100_i[0] && !activity_i[0] && !all_on
		|-> !ind_lnk[0] && ind_spd[0];
	endproperty
	a_bi10: assert property (p_bi10)
		else $error("yellow wrong");
	property p_direct;
		@(posedge clk_i) disable iff (rst_i)
		fmt == FMT_DIRECT |=> spd_led_o == $past(ind_spd);
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct stale");
endmodule

// File: verification/lsout_sreg_model.sv
// Shift-register partner that captures serial LED frames
`timescale 1ns/1ps
module lsout_sreg_model (
	// Clock
	input  wire logic        clk_i,
	// Serial stream
	input  wire logic        led_data_i,
	input  wire logic        led_clk_i,
	// Captured frame
	output logic      [23:0] frame_o,
	output int               nbits_o,
	output int               frames_o
);
	logic [23:0] sh = '0;
	logic        clk_q = 1'b1;
	int          n = 0;
	int          idle = 0;
	initial begin
		frame_o = '0;
		nbits_o = 0;
		frames_o = 0;
	end
	// A quiet shift clock for 12 cycles marks the frame gap
	always @(posedge clk_i) begin
		clk_q <= led_clk_i;
		if (led_clk_i && !clk_q) begin
			sh <= {sh[22:0], led_data_i};
			n <= n + 1;
			idle <= 0;
		end else begin
			idle <= idle + 1;
			if (idle == 12 && n != 0) begin
				frame_o <= sh;
				nbits_o <= n;
				frames_o <= frames_o + 1;
				n <= 0;
			end
		end
	end
endmodule

// File: verification/led_status_output_tb.sv
// Self-checking bench for the LED status formatter
`timescale 1ns/1ps
module led_status_output_tb
	import lsout_pkg::*;
;
	localparam int CA = 20;
	localparam int CB = 40;
	localparam int CD = 50;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [1:0]  fmt = 2'h0;
	logic        keep = 1'b1, per = 1'b0, inh = 1'b1;
	logic [7:0]  lnk = '0, spd = '0, dup = '0, col = '0, act = '0;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0]  adr = '0;
	logic [31:0] dat = '0, dat_o;
	logic        ack_o, led_data_o, led_clk_o;
	logic [7:0]  cdo, lao, spo;
	logic [23:0] frame;
	int          nbits, frames;
	int          num_errors = 0;
	int          check_count = 0;
	initial forever #20 clk_i = ~clk_i;
	lsout_core #(.CYC_A(CA), .CYC_B(CB), .CYC_DIAG(CD)) lsout_core_i (
		.clk_i(clk_i), .rst_i(rst_i), .led_format_select_i(fmt),
		.collision_blink_keep_strap_i(keep), .blink_period_select_i(per),
		.startup_blink_inhibit_i(inh), .link_up_i(lnk), .speed_100_i(spd),
		.full_duplex_i(dup), .collision_i(col), .activity_i(act),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf),
		.dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .led_data_o(led_data_o),
		.led_clk_o(led_clk_o), .col_dup_led_o(cdo), .link_act_led_o(lao),
		.spd_led_o(spo));
	lsout_sreg_model lsout_sreg_model_i (.clk_i(clk_i),
		.led_data_i(led_data_o), .led_clk_i(led_clk_o), .frame_o(frame),
		.nbits_o(nbits), .frames_o(frames));
	// ****************************************
	// Shared tasks and reference model
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) begin
			num_errors++;
			report_and_stop();
		end
	endtask
	task automatic rst(input logic [1:0] f, input logic k, input logic p,
		input logic i);
		@(posedge clk_i);
		rst_i <= 1'b1;
		fmt <= f;
		keep <= k;
		per <= p;
		inh <= i;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	// Static indications, no collision or traffic
	function automatic logic [2:0] ind(input int f, input int p);
		logic sp, la;
		sp = ~spd[p];
		la = ~lnk[p];
		if (f == 2)
			la = lnk[p] ? spd[p] : sp;
		return {~dup[p], la, sp};
	endfunction
	initial begin
		logic [31:0] q;
		logic [23:0] ef;
		logic [2:0]  e;
		logic        k, p, a, b;
		int          n, f0, t0, t1;
		void'($urandom(32'h86ed));
		for (int f = 0; f < 4; f++) begin
			lnk <= 8'($urandom);
			spd <= 8'($urandom);
			dup <= 8'($urandom);
			// Bi-color run keeps collisions on with blinking suppressed
			k = (f == 2) ? 1'b0 : 1'($urandom);
			col <= (f == 2) ? 8'hff : 8'h00;
			p = 1'($urandom);
			rst(f[1:0], k, p, 1'b1);
			wb(1'b0, ADR_CFG, '0, q);
			chk(q, {27'h0, 1'b1, p, k, f[1:0]});
			ef = '0;
			for (int j = 0; j < 8; j++) begin
				e = ind(f, j);
				ef = (f == 1) ? {ef[21:0], e[0], e[1]} : {ef[20:0], e};
			end
			if (f != 3) begin
				f0 = frames;
				n = 0;
				while (frames < f0 + 2 && n < 2000) begin
					@(posedge clk_i);
					n++;
				end
				if (n >= 2000) begin
					num_errors++;
					report_and_stop();
				end
				chk((f == 1) ? {8'h0, frame[15:0]} : frame, ef);
				chk(nbits, (f == 1) ? 16 : 24);
				chk({cdo, lao, spo}, 32'hffffff);
			end else begin
				repeat (3) @(posedge clk_i);
				for (int j = 0; j < 8; j++) begin
					chk({cdo[j], lao[j], spo[j]}, ind(f, j));
				end
				chk({led_clk_o, led_data_o}, 2'b11);
				wb(1'b0, ADR_CTRL, '0, q);
				chk(q, '0);
				wb(1'b1, ADR_CTRL, 32'h1, q);
				wb(1'b0, ADR_CTRL, '0, q);
				chk(q, 32'h1);
				repeat (3) @(posedge clk_i);
				chk({cdo, lao, spo}, '0);
				wb(1'b1, ADR_CTRL, '0, q);
			end
			wb(1'b0, 4'hc, '0, q);
			chk(q, '0);
		end
		// Toggle count over a fixed window pins the blink period
		for (int j = 0; j < 2; j++) begin
			lnk <= 8'hff;
			dup <= 8'h00;
			col <= 8'h01;
			act <= 8'h02;
			rst(FMT_DIRECT, 1'b1, j[0], 1'b1);
			repeat (CB) @(posedge clk_i);
			t0 = 0;
			t1 = 0;
			a = cdo[0];
			b = lao[1];
			repeat (2 * CA) begin
				@(posedge clk_i);
				if (cdo[0] !== a) t0++;
				if (lao[1] !== b) t1++;
				a = cdo[0];
				b = lao[1];
			end
			chk(t0, j ? 2 : 4);
			chk(t1, j ? 2 : 4);
		end
		rst(FMT_DIRECT, 1'b1, 1'b0, 1'b0);
		repeat (3) @(posedge clk_i);
		chk(spo, 8'h00);
		wb(1'b0, ADR_STAT, '0, q);
		chk({q[31:1], 1'b0}, 32'h2);
		repeat (CD + 2) @(posedge clk_i);
		chk(spo, {~spd});
		wb(1'b0, ADR_STAT, '0, q);
		chk({q[31:1], 1'b0}, 32'h0);
		report_and_stop();
	end
endmodule
